// [rdc_pkg.sv]
// package: register map, field layout and reset values of the decoder registers
package rdc_pkg;

    // ========================================================================
    // register offsets
    localparam logic [15:0] CH1_CONTROL_OFS  = 16'h6005;
    localparam logic [15:0] CH2_STATUS_OFS   = 16'h6008;
    localparam logic [15:0] CH2_LAST_OFS     = 16'h6009;
    localparam logic [15:0] CH2_PREV_OFS     = 16'h600A;
    localparam logic [15:0] CH2_COUNTERS_OFS = 16'h600B;
    localparam logic [15:0] CH2_SETTINGS_OFS = 16'h600C;
    localparam logic [15:0] CH2_CONTROL_OFS  = 16'h600D;

    // ========================================================================
    // control register fields (both channels)
    localparam int CTL_SEL_BIT     = 10;
    localparam int CTL_CLKOUT_BIT  = 9;
    localparam int CTL_CLKIN_BIT   = 8;
    localparam int CTL_ACC_HI      = 7;
    localparam int CTL_ACC_LO      = 6;
    localparam int CTL_RESYNC_BIT  = 5;
    localparam int CTL_GAIN_HI     = 4;
    localparam int CTL_GAIN_LO     = 0;
    localparam logic [15:0] CTL_WMASK = 16'h07DF;
    localparam logic [15:0] CTL_RESET = 16'h0100;

    // ========================================================================
    // settings register fields
    localparam int SET_COR_HI   = 14;
    localparam int SET_COR_LO   = 13;
    localparam int SET_GOOD_HI  = 12;
    localparam int SET_GOOD_LO  = 7;
    localparam int SET_EBLK_BIT = 6;
    localparam int SET_BAD_HI   = 5;
    localparam int SET_BAD_LO   = 0;
    localparam logic [15:0] SET_WMASK = 16'h7FFF;
    localparam logic [15:0] SET_RESET = 16'h1020;

    // ========================================================================
    // identifiers and reset values of status fields
    localparam logic [2:0]  BLOCK_ID_RESET = 3'h7;
    localparam logic [15:0] WORD_RESET     = 16'h0000;

    typedef enum logic [1:0] {
        RDC_CLK_DECODER, RDC_CLK_BURST, RDC_CLK_DEMOD, RDC_CLK_BAD
    } rdc_clk_mode_e;

    typedef enum logic [1:0] {
        RDC_ACC_STANDARD, RDC_ACC_FAST_PI, RDC_ACC_REDUCED, RDC_ACC_BYPASS
    } rdc_acc_mode_e;

    typedef enum logic [1:0] {
        RDC_COR_NONE, RDC_COR_BURST2, RDC_COR_BURST5, RDC_COR_NONE2
    } rdc_cor_mode_e;

    // one block report from the decoder datapath
    typedef struct packed {
        logic [15:0] word;
        logic [2:0]  id;
        logic [1:0]  err;
        logic        good;
    } rdc_block_s;

    // register bus request
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } rdc_bus_s;

endpackage

// [rdc_regs.sv]
// control, settings and status registers of the radio data decoder
`timescale 1ns/10ps

// How it works
// RULE1 - ch2 control bit 10 picks second indicator: decoder or IF flag.
// RULE2 - clock mode bits 9:8: decoder, burst or demodulator; 11 forbidden.
// RULE3 - access bits 7:6: standard, fast search, reduced, bypass; reset 00.
// RULE4 - writing 1 to bit 5 starts new sync search; 0 changes nothing.
// RULE5 - bits 4:0 hold bad-block gain threshold, reset zero.
// RULE6 - settings bits 14:13 select correction: none, 2-bit or 5-bit bursts.
// RULE7 - settings bits 12:7 hold good-block loss threshold, reset 100000.
// RULE8 - settings bits 5:0 hold bad-block loss threshold, reset 100000.
// RULE9 - settings bit 6 accepts E blocks when set, reset 0.
// RULE10 - counter bits 15:10 show six-bit bad-block counter, reset zero.
// RULE11 - counter bits 9:5 show top five bits of good-block counter.
// RULE12 - counter shows previous block id (reset 111) and its error status.
// RULE13 - sixteen-bit register holds previous block word, reset zero.
// RULE14 - sixteen-bit register holds last block word, reset zero.
// RULE15 - status bit 7 reads 1 while sync found, reset 0.
// RULE16 - status bit 6 set on data overflow before read.
// RULE17 - status bit 5 reads 1 when decoder reset seen.
// RULE18 - status bits 4:2 give last block id, reset 111.
// RULE19 - status bits 1:0 give last block error status, reset 00.
// RULE20 - ch1 control bit 10 gives shared pin indicator or ch1 data clock.
// RULE21 - ch1 control has same clock, access, restart and gain fields.
// RULE22 - a restart write acts once, not while the bit stays set.
module rdc_regs
    import rdc_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    input  wire logic        blk_valid_i,
    input  wire logic [15:0] blk_word_i,
    input  wire logic [2:0]  blk_id_i,
    input  wire logic [1:0]  blk_err_i,
    input  wire logic        blk_good_i,
    input  wire logic        sync_found_i,
    input  wire logic        decoder_reset_i,
    input  wire logic        ch2_avail_i,
    input  wire logic        if_flag_i,
    input  wire logic        ch1_data_clock_i,
    output logic             shared_clock_indicator_pin_o,
    output logic             ch1_restart_sync_o,
    output logic             ch2_restart_sync_o,
    output logic      [1:0]  ch1_clock_mode_o,
    output logic      [1:0]  ch2_clock_mode_o,
    output logic      [1:0]  ch1_access_mode_o,
    output logic      [1:0]  ch2_access_mode_o,
    output logic      [4:0]  ch1_bad_gain_threshold_o,
    output logic      [4:0]  ch2_bad_gain_threshold_o,
    output logic      [1:0]  ch2_correction_mode_o,
    output logic      [5:0]  ch2_good_lose_threshold_o,
    output logic             ch2_e_block_allow_o,
    output logic      [5:0]  ch2_bad_lose_threshold_o
);

    // ========================================================================
    // helpers
    function automatic logic [15:0] merge_ctl(input logic [15:0] old_v,
                                              input logic [15:0] new_v);
        logic [15:0] v;
        v = (new_v & CTL_WMASK) & ~(16'h0001 << CTL_RESYNC_BIT);
        // forbidden clock mode 11 is refused; the old mode is kept
        if (new_v[CTL_CLKOUT_BIT] && new_v[CTL_CLKIN_BIT]) begin //RULE2
            v[CTL_CLKOUT_BIT] = old_v[CTL_CLKOUT_BIT];
            v[CTL_CLKIN_BIT]  = old_v[CTL_CLKIN_BIT];
        end
        return v;
    endfunction

    // ========================================================================
    // synchronisers for pin inputs
    logic [1:0] avail_sync_reg;
    logic [1:0] flag_sync_reg;
    logic [1:0] clk1_sync_reg;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            avail_sync_reg <= 2'h0;
            flag_sync_reg  <= 2'h0;
            clk1_sync_reg  <= 2'h0;
        end else begin
            avail_sync_reg <= {avail_sync_reg[0], ch2_avail_i};
            flag_sync_reg  <= {flag_sync_reg[0], if_flag_i};
            clk1_sync_reg  <= {clk1_sync_reg[0], ch1_data_clock_i};
        end
    end

    // ========================================================================
    // address decode
    rdc_bus_s bus;
    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    wire wr_ctl1 = bus.wr && (bus.addr == CH1_CONTROL_OFS);
    wire wr_ctl2 = bus.wr && (bus.addr == CH2_CONTROL_OFS);
    wire wr_set2 = bus.wr && (bus.addr == CH2_SETTINGS_OFS);
    wire rd_stat = bus.rd && (bus.addr == CH2_STATUS_OFS);

    // ========================================================================
    // control and settings storage
    logic [15:0] ctl1_reg;
    logic [15:0] ctl2_reg;
    logic [15:0] set2_reg;
    logic        resync1_reg;
    logic        resync2_reg;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctl1_reg    <= CTL_RESET; //RULE21
            ctl2_reg    <= CTL_RESET; //RULE2
            set2_reg    <= SET_RESET; //RULE7
            resync1_reg <= 1'b0;
            resync2_reg <= 1'b0;
        end else begin
            if (wr_ctl1) begin
                ctl1_reg <= merge_ctl(ctl1_reg, bus.wdata); //RULE21
            end
            if (wr_ctl2) begin
                ctl2_reg <= merge_ctl(ctl2_reg, bus.wdata); //RULE1
            end
            if (wr_set2) begin
                set2_reg <= bus.wdata & SET_WMASK; //RULE6
            end
            // restart is a one-cycle pulse per write of 1
            resync1_reg <= wr_ctl1 && bus.wdata[CTL_RESYNC_BIT]; //RULE22
            resync2_reg <= wr_ctl2 && bus.wdata[CTL_RESYNC_BIT]; //RULE4
        end
    end

    // ========================================================================
    // block reports, counters and status
    rdc_block_s  blk;
    logic [15:0] last_word_reg;
    logic [15:0] prev_word_reg;
    logic [2:0]  last_id_reg;
    logic [2:0]  prev_id_reg;
    logic [1:0]  last_err_reg;
    logic [1:0]  prev_err_reg;
    logic [5:0]  bad_cnt_reg;
    logic [5:0]  good_cnt_reg;
    logic        sync_reg;
    logic        ovf_reg;
    logic        rst_seen_reg;
    logic        unread_reg;

    assign blk = '{word: blk_word_i, id: blk_id_i, err: blk_err_i,
                   good: blk_good_i};

    wire restart_any = resync1_reg || resync2_reg;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            last_word_reg <= WORD_RESET; //RULE14
            prev_word_reg <= WORD_RESET; //RULE13
            last_id_reg   <= BLOCK_ID_RESET; //RULE18
            prev_id_reg   <= BLOCK_ID_RESET; //RULE12
            last_err_reg  <= 2'h0; //RULE19
            prev_err_reg  <= 2'h0;
            bad_cnt_reg   <= 6'h00; //RULE10
            good_cnt_reg  <= 6'h00; //RULE11
            sync_reg      <= 1'b0;
            ovf_reg       <= 1'b0;
            rst_seen_reg  <= 1'b0;
            unread_reg    <= 1'b0;
        end else begin
            sync_reg <= sync_found_i; //RULE15
            if (blk_valid_i) begin
                prev_word_reg <= last_word_reg; //RULE13
                last_word_reg <= blk.word; //RULE14
                prev_id_reg   <= last_id_reg; //RULE12
                last_id_reg   <= blk.id; //RULE18
                prev_err_reg  <= last_err_reg;
                last_err_reg  <= blk.err; //RULE19
            end
            if (restart_any) begin
                bad_cnt_reg  <= 6'h00;
                good_cnt_reg <= 6'h00;
            end else if (blk_valid_i && blk.good) begin
                good_cnt_reg <= 6'(good_cnt_reg + 6'h01); //RULE11
            end else if (blk_valid_i) begin
                bad_cnt_reg <= 6'(bad_cnt_reg + 6'h01); //RULE10
            end
            // a new block while the last is unread sets overflow; set wins
            if (blk_valid_i) begin
                unread_reg <= 1'b1;
            end else if (rd_stat) begin
                unread_reg <= 1'b0;
            end
            if (blk_valid_i && unread_reg) begin
                ovf_reg <= 1'b1; //RULE16
            end else if (rd_stat) begin
                ovf_reg <= 1'b0;
            end
            if (decoder_reset_i) begin
                rst_seen_reg <= 1'b1; //RULE17
            end else if (rd_stat) begin
                rst_seen_reg <= 1'b0;
            end
        end
    end

    // ========================================================================
    // read mux
    wire [15:0] stat_word = {8'h00, sync_reg, ovf_reg, rst_seen_reg,
                             last_id_reg, last_err_reg};
    wire [15:0] cnt_word  = {bad_cnt_reg, good_cnt_reg[5:1], prev_id_reg,
                             prev_err_reg}; //RULE12
    logic [15:0] rd_sel;

    always_comb begin
        case (bus.addr)
            CH1_CONTROL_OFS:  rd_sel = ctl1_reg;
            CH2_STATUS_OFS:   rd_sel = stat_word;
            CH2_LAST_OFS:     rd_sel = last_word_reg;
            CH2_PREV_OFS:     rd_sel = prev_word_reg;
            CH2_COUNTERS_OFS: rd_sel = cnt_word;
            CH2_SETTINGS_OFS: rd_sel = set2_reg;
            CH2_CONTROL_OFS:  rd_sel = ctl2_reg;
            default:          rd_sel = 16'h0000;
        endcase
    end

    // ========================================================================
    // shared pin select
    wire indicator = ctl2_reg[CTL_SEL_BIT] ? flag_sync_reg[1]
                                           : avail_sync_reg[1]; //RULE1
    wire pin_next  = ctl1_reg[CTL_SEL_BIT] ? indicator
                                           : clk1_sync_reg[1]; //RULE20

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o                      <= 16'h0000;
            shared_clock_indicator_pin_o <= 1'b0;
        end else begin
            rdata_o                      <= bus.rd ? rd_sel : 16'h0000;
            shared_clock_indicator_pin_o <= pin_next; //RULE20
        end
    end

    // ========================================================================
    // field outputs
    assign ch1_restart_sync_o        = resync1_reg;
    assign ch2_restart_sync_o        = resync2_reg;
    assign ch1_clock_mode_o          = ctl1_reg[CTL_CLKOUT_BIT:CTL_CLKIN_BIT];
    assign ch2_clock_mode_o          = ctl2_reg[CTL_CLKOUT_BIT:CTL_CLKIN_BIT];
    assign ch1_access_mode_o         = ctl1_reg[CTL_ACC_HI:CTL_ACC_LO];
    assign ch2_access_mode_o         = ctl2_reg[CTL_ACC_HI:CTL_ACC_LO]; //RULE3
    assign ch1_bad_gain_threshold_o  = ctl1_reg[CTL_GAIN_HI:CTL_GAIN_LO];
    assign ch2_bad_gain_threshold_o  =
        ctl2_reg[CTL_GAIN_HI:CTL_GAIN_LO]; //RULE5
    assign ch2_correction_mode_o     = set2_reg[SET_COR_HI:SET_COR_LO]; //RULE6
    assign ch2_good_lose_threshold_o =
        set2_reg[SET_GOOD_HI:SET_GOOD_LO]; //RULE7
    assign ch2_e_block_allow_o       = set2_reg[SET_EBLK_BIT]; //RULE9
    assign ch2_bad_lose_threshold_o  = set2_reg[SET_BAD_HI:SET_BAD_LO]; //RULE8

    // ========================================================================
    // checks
    chk_no_bad_clock: assert property ( //RULE2
        @(posedge clock_i) disable iff (!resetn_i)
        ch2_clock_mode_o != 2'h3 && ch1_clock_mode_o != 2'h3)
        else $error("forbidden clock mode stored");

    chk_restart_pulse: assert property ( //RULE4
        @(posedge clock_i) disable iff (!resetn_i)
        (wr_ctl2 && bus.wdata[CTL_RESYNC_BIT]) |=> ch2_restart_sync_o
        ##1 (!ch2_restart_sync_o
             || $past(wr_ctl2 && bus.wdata[CTL_RESYNC_BIT])))
        else $error("restart not a single pulse");

    chk_restart_once: assert property ( //RULE22
        @(posedge clock_i) disable iff (!resetn_i)
        ch1_restart_sync_o |-> $past(wr_ctl1 && bus.wdata[CTL_RESYNC_BIT]))
        else $error("restart without write");

    chk_read_latency: assert property ( //RULE7
        @(posedge clock_i) disable iff (!resetn_i)
        (bus.rd && bus.addr == CH2_SETTINGS_OFS && !$past(bus.wr))
        |=> rdata_o == $past(set2_reg))
        else $error("settings read wrong");

    chk_last_to_prev: assert property ( //RULE13
        @(posedge clock_i) disable iff (!resetn_i)
        blk_valid_i |=> prev_word_reg == $past(last_word_reg)
        && last_word_reg == $past(blk_word_i))
        else $error("block words not shifted");

    chk_overflow_set: assert property ( //RULE16
        @(posedge clock_i) disable iff (!resetn_i)
        (blk_valid_i && unread_reg) |=> ovf_reg)
        else $error("overflow missed");

    chk_reset_seen: assert property ( //RULE17
        @(posedge clock_i) disable iff (!resetn_i)
        decoder_reset_i |=> rst_seen_reg ##1 (rst_seen_reg || $past(rd_stat)))
        else $error("decoder reset not held");

    chk_bad_count: assert property ( //RULE10
        @(posedge clock_i) disable iff (!resetn_i)
        (blk_valid_i && !blk_good_i && !restart_any)
        |=> bad_cnt_reg == 6'($past(bad_cnt_reg) + 6'h01))
        else $error("bad counter not advanced");

    chk_good_count: assert property ( //RULE11
        @(posedge clock_i) disable iff (!resetn_i)
        (blk_valid_i && blk_good_i && !restart_any)
        |=> good_cnt_reg == 6'($past(good_cnt_reg) + 6'h01))
        else $error("good counter not advanced");

    chk_count_clear: assert property ( //RULE4
        @(posedge clock_i) disable iff (!resetn_i)
        restart_any |=> bad_cnt_reg == 6'h00 && good_cnt_reg == 6'h00)
        else $error("counters not cleared on restart");

    chk_sync_track: assert property ( //RULE15
        @(posedge clock_i) disable iff (!resetn_i)
        sync_found_i |=> stat_word[7])
        else $error("sync bit not shown");

    chk_sync_clear: assert property ( //RULE15
        @(posedge clock_i) disable iff (!resetn_i)
        !sync_found_i |=> !stat_word[7])
        else $error("sync bit shown without sync");

    chk_id_shift: assert property ( //RULE18
        @(posedge clock_i) disable iff (!resetn_i)
        blk_valid_i |=> last_id_reg == $past(blk_id_i)
        && prev_id_reg == $past(last_id_reg))
        else $error("block ids not shifted");

    chk_err_shift: assert property ( //RULE19
        @(posedge clock_i) disable iff (!resetn_i)
        blk_valid_i |=> last_err_reg == $past(blk_err_i)
        && prev_err_reg == $past(last_err_reg))
        else $error("error status not shifted");

    chk_select_write: assert property ( //RULE1
        @(posedge clock_i) disable iff (!resetn_i)
        wr_ctl2 |=> ctl2_reg[CTL_SEL_BIT] == $past(bus.wdata[CTL_SEL_BIT]))
        else $error("indicator select not stored");

    chk_access_write: assert property ( //RULE3
        @(posedge clock_i) disable iff (!resetn_i)
        wr_ctl2 |=> ch2_access_mode_o
        == $past(bus.wdata[CTL_ACC_HI:CTL_ACC_LO]))
        else $error("access mode not stored");

    chk_gain_write: assert property ( //RULE5
        @(posedge clock_i) disable iff (!resetn_i)
        wr_ctl2 |=> ch2_bad_gain_threshold_o
        == $past(bus.wdata[CTL_GAIN_HI:CTL_GAIN_LO]))
        else $error("gain threshold not stored");

    chk_resync_not_stored: assert property ( //RULE4
        @(posedge clock_i) disable iff (!resetn_i)
        !ctl1_reg[CTL_RESYNC_BIT] && !ctl2_reg[CTL_RESYNC_BIT])
        else $error("restart bit stored");

    chk_ch1_fields: assert property ( //RULE21
        @(posedge clock_i) disable iff (!resetn_i)
        wr_ctl1 |=> ch1_access_mode_o
        == $past(bus.wdata[CTL_ACC_HI:CTL_ACC_LO])
        && ch1_bad_gain_threshold_o
        == $past(bus.wdata[CTL_GAIN_HI:CTL_GAIN_LO]))
        else $error("ch1 control fields not stored");

    chk_correction_write: assert property ( //RULE6
        @(posedge clock_i) disable iff (!resetn_i)
        wr_set2 |=> ch2_correction_mode_o
        == $past(bus.wdata[SET_COR_HI:SET_COR_LO]))
        else $error("correction mode not stored");

    chk_good_lose_write: assert property ( //RULE7
        @(posedge clock_i) disable iff (!resetn_i)
        wr_set2 |=> ch2_good_lose_threshold_o
        == $past(bus.wdata[SET_GOOD_HI:SET_GOOD_LO]))
        else $error("good loss threshold not stored");

    chk_bad_lose_write: assert property ( //RULE8
        @(posedge clock_i) disable iff (!resetn_i)
        wr_set2 |=> ch2_bad_lose_threshold_o
        == $past(bus.wdata[SET_BAD_HI:SET_BAD_LO]))
        else $error("bad loss threshold not stored");

    chk_eblock_write: assert property ( //RULE9
        @(posedge clock_i) disable iff (!resetn_i)
        wr_set2 |=> ch2_e_block_allow_o == $past(bus.wdata[SET_EBLK_BIT]))
        else $error("e block allow not stored");

    chk_pin_clock: assert property ( //RULE20
        @(posedge clock_i) disable iff (!resetn_i)
        !$past(ctl1_reg[CTL_SEL_BIT])
        |-> shared_clock_indicator_pin_o == $past(clk1_sync_reg[1]))
        else $error("shared pin not on ch1 clock");

    chk_pin_flag: assert property ( //RULE1
        @(posedge clock_i) disable iff (!resetn_i)
        $past(ctl1_reg[CTL_SEL_BIT] && ctl2_reg[CTL_SEL_BIT])
        |-> shared_clock_indicator_pin_o == $past(flag_sync_reg[1]))
        else $error("shared pin not on processor flag");

endmodule

// [rdc_blk_host.sv]
// partner model: decoder datapath end that reports decoded blocks
`timescale 1ns/10ps
module rdc_blk_host
    import rdc_pkg::*;
(
    input  wire logic        clock_i,
    output logic             blk_valid_o,
    output logic      [15:0] blk_word_o,
    output logic      [2:0]  blk_id_o,
    output logic      [1:0]  blk_err_o,
    output logic             blk_good_o
);
    initial begin
        blk_valid_o = 1'b0;
        blk_word_o  = 16'h0000;
        blk_id_o    = 3'h0;
        blk_err_o   = 2'h0;
        blk_good_o  = 1'b0;
    end

    // ========================================================================
    // one-cycle report; fields scrambled once the pulse is over
    task automatic send(input logic [15:0] w, input logic [2:0] i,
                        input logic [1:0] e, input logic g);
        @(posedge clock_i);
        blk_valid_o <= 1'b1;
        blk_word_o  <= w;
        blk_id_o    <= i;
        blk_err_o   <= e;
        blk_good_o  <= g;
        @(posedge clock_i);
        blk_valid_o <= 1'b0;
        blk_word_o  <= ~w;
        blk_id_o    <= ~i;
        blk_err_o   <= ~e;
        blk_good_o  <= ~g;
        #1;
    endtask
endmodule

// [testbench.sv]
// self-checking testbench of the decoder register bank
`timescale 1ns/10ps
module testbench;
    import rdc_pkg::*;
    logic        clock_i, resetn_i, wr, rd, sync, dres, avail, iflag, c1clk;
    logic [15:0] addr, wdata, rdata, bw;
    logic        pin, rs1, rs2, eb, bv, bg;
    logic [1:0]  cm1, cm2, am1, am2, cor, be;
    logic [4:0]  g1, g2;
    logic [5:0]  gl, bl;
    logic [2:0]  bi;
    int          n_errors = 0;
    int          cmp_count = 0;

    initial clock_i = 1'b0;
    always #5 clock_i = ~clock_i;

    rdc_regs i_dut (.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .blk_valid_i(bv), .blk_word_i(bw), .blk_id_i(bi), .blk_err_i(be),
        .blk_good_i(bg), .sync_found_i(sync), .decoder_reset_i(dres),
        .ch2_avail_i(avail), .if_flag_i(iflag), .ch1_data_clock_i(c1clk),
        .shared_clock_indicator_pin_o(pin), .ch1_restart_sync_o(rs1),
        .ch2_restart_sync_o(rs2), .ch1_clock_mode_o(cm1),
        .ch2_clock_mode_o(cm2), .ch1_access_mode_o(am1),
        .ch2_access_mode_o(am2), .ch1_bad_gain_threshold_o(g1),
        .ch2_bad_gain_threshold_o(g2), .ch2_correction_mode_o(cor),
        .ch2_good_lose_threshold_o(gl), .ch2_e_block_allow_o(eb),
        .ch2_bad_lose_threshold_o(bl));

    rdc_blk_host i_host (.clock_i(clock_i), .blk_valid_o(bv),
        .blk_word_o(bw), .blk_id_o(bi), .blk_err_o(be), .blk_good_o(bg));

    // ========================================================================
    // shared tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus_wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clock_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock_i);
        wr <= 1'b0;
        #1;
    endtask

    task automatic bus_rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clock_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock_i);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic pins(input logic c, input logic v, input logic f);
        @(posedge clock_i);
        c1clk <= c;
        avail <= v;
        iflag <= f;
        repeat (4) @(posedge clock_i);
        #1;
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ========================================================================
    // scenarios
    task automatic t_reset;
        chk({14'h0, cm2}, 16'h0001);
        bus_rd(CH2_CONTROL_OFS, 16'h0100);
        bus_rd(CH1_CONTROL_OFS, 16'h0100);
        bus_rd(CH2_SETTINGS_OFS, 16'h1020);
        bus_rd(CH2_COUNTERS_OFS, 16'h001C);
        bus_rd(CH2_PREV_OFS, 16'h0000);
        bus_rd(CH2_LAST_OFS, 16'h0000);
        bus_rd(CH2_STATUS_OFS, 16'h001C);
        bus_rd(16'h6006, 16'h0000);
    endtask

    task automatic t_ctl;
        logic [15:0] v;
        logic [1:0]  e;
        bus_wr(CH2_CONTROL_OFS, 16'hFFFF);
        chk({14'h0, rs1, rs2}, 16'h0001);
        @(posedge clock_i);
        #1;
        chk({15'h0, rs2}, 16'h0000);
        bus_rd(CH2_CONTROL_OFS, 16'h05DF);
        for (int m = 0; m < 4; m++) begin
            v = {6'h00, m[1:0], m[1:0], 1'b0, 5'(m + 9)};
            e = (m == 3) ? 2'h2 : m[1:0];
            bus_wr(CH2_CONTROL_OFS, v);
            chk({15'h0, rs2}, 16'h0000);
            bus_wr(CH1_CONTROL_OFS, v);
            chk({cm1, cm2, am1, am2, 3'h0, g1},
                {e, e, m[1:0], m[1:0], 3'h0, 5'(m + 9)});
            chk({11'h0, g2}, {11'h0, 5'(m + 9)});
            bus_rd(CH2_CONTROL_OFS, {6'h00, e, v[7:0]});
        end
        bus_wr(CH1_CONTROL_OFS, 16'h0020);
        chk({14'h0, rs1, rs2}, 16'h0002);
        @(posedge clock_i);
        #1;
        chk({15'h0, rs1}, 16'h0000);
    endtask

    task automatic t_set;
        bus_wr(CH2_SETTINGS_OFS, 16'hFFFF);
        bus_rd(CH2_SETTINGS_OFS, 16'h7FFF);
        chk({gl, bl, eb, 3'h0}, 16'hFFF8);
        for (int m = 0; m < 4; m++) begin
            bus_wr(CH2_SETTINGS_OFS, {1'b0, m[1:0], 6'h15, 1'b0, 6'h2A});
            chk({14'h0, cor}, {14'h0, m[1:0]});
        end
        chk({gl, bl, eb, 3'h0}, {6'h15, 6'h2A, 4'h0});
    endtask

    task automatic t_blocks;
        i_host.send(16'hA5C3, 3'h1, 2'h0, 1'b1);
        bus_rd(CH2_LAST_OFS, 16'hA5C3);
        i_host.send(16'h3C5A, 3'h2, 2'h3, 1'b0);
        bus_rd(CH2_PREV_OFS, 16'hA5C3);
        bus_rd(CH2_LAST_OFS, 16'h3C5A);
        bus_rd(CH2_COUNTERS_OFS, 16'h0404);
        bus_rd(CH2_STATUS_OFS, 16'h004B);
        bus_rd(CH2_STATUS_OFS, 16'h000B);
        i_host.send(16'h1234, 3'h5, 2'h1, 1'b1);
        i_host.send(16'h8001, 3'h4, 2'h2, 1'b1);
        bus_rd(CH2_COUNTERS_OFS, 16'h0435);
        bus_rd(CH2_STATUS_OFS, 16'h0052);
        @(posedge clock_i);
        sync <= 1'b1;
        dres <= 1'b1;
        @(posedge clock_i);
        dres <= 1'b0;
        repeat (2) @(posedge clock_i);
        bus_rd(CH2_STATUS_OFS, 16'h00B2);
        bus_rd(CH2_STATUS_OFS, 16'h0092);
        @(posedge clock_i);
        sync <= 1'b0;
        repeat (2) @(posedge clock_i);
        bus_rd(CH2_STATUS_OFS, 16'h0012);
        bus_wr(CH2_CONTROL_OFS, 16'h0020);
        bus_rd(CH2_COUNTERS_OFS, 16'h0015);
    endtask

    task automatic t_pin;
        bus_wr(CH1_CONTROL_OFS, 16'h0100);
        pins(1'b1, 1'b0, 1'b0);
        chk({15'h0, pin}, 16'h0001);
        pins(1'b0, 1'b1, 1'b1);
        chk({15'h0, pin}, 16'h0000);
        bus_wr(CH1_CONTROL_OFS, 16'h0500);
        bus_wr(CH2_CONTROL_OFS, 16'h0100);
        pins(1'b0, 1'b1, 1'b0);
        chk({15'h0, pin}, 16'h0001);
        bus_wr(CH2_CONTROL_OFS, 16'h0500);
        pins(1'b1, 1'b1, 1'b0);
        chk({15'h0, pin}, 16'h0000);
        pins(1'b0, 1'b0, 1'b1);
        chk({15'h0, pin}, 16'h0001);
    endtask

    task automatic t_rerun;
        bus_wr(CH2_SETTINGS_OFS, 16'h0000);
        @(posedge clock_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        resetn_i <= 1'b1;
        bus_rd(CH2_SETTINGS_OFS, 16'h1020);
        bus_rd(CH1_CONTROL_OFS, 16'h0100);
    endtask

    // ========================================================================
    // main sequence and watchdog
    initial begin
        resetn_i = 1'b0;
        addr     = 16'h0000;
        wdata    = 16'h0000;
        wr       = 1'b0;
        rd       = 1'b0;
        sync     = 1'b0;
        dres     = 1'b0;
        avail    = 1'b0;
        iflag    = 1'b0;
        c1clk    = 1'b0;
        repeat (6) @(posedge clock_i);
        resetn_i <= 1'b1;
        t_reset();
        t_ctl();
        t_set();
        t_blocks();
        t_pin();
        t_rerun();
        stop_test();
    end

    initial begin
        #50000;
        n_errors++;
        stop_test();
    end
endmodule
